// ===== rtl/smg_pkg.sv
// package for the sleep mode domain gating block
// assumes one 250 MHz clock domain; shared by the design and its bench
package smg_pkg;

  // ==========================================================
  // sleep mode selection codes
  typedef enum logic [2:0] {
    SMG_MODE_IDLE    = 3'b000,
    SMG_MODE_ADCNR   = 3'b001,
    SMG_MODE_PDOWN   = 3'b010,
    SMG_MODE_PSAVE   = 3'b011,
    SMG_MODE_STBY    = 3'b110,
    SMG_MODE_XSTBY   = 3'b111
  } smg_mode_t;

  // ==========================================================
  // controller states
  typedef enum logic [1:0] {
    SMG_ST_RUN   = 2'b00,
    SMG_ST_SLEEP = 2'b01,
    SMG_ST_RESET = 2'b10
  } smg_state_t;

  // ==========================================================
  // domain gate vector bit positions
  localparam int SMG_DOM_CPU   = 0;
  localparam int SMG_DOM_IO    = 1;
  localparam int SMG_DOM_ADC   = 2;
  localparam int SMG_DOM_OSC   = 3;
  localparam int SMG_DOM_ATMR  = 4;
  localparam int SMG_DOM_INTR  = 5;
  localparam int SMG_DOM_W     = 6;
  localparam logic [5:0] SMG_DOM_ALL  = 6'h3F;
  localparam logic [5:0] SMG_DOM_NONE = 6'h00;

  // ==========================================================
  // external reset minimum pulse, ns, and its cycle count (round up)
  localparam int SMG_CLK_PERIOD_NS   = 4;
  localparam int SMG_RST_MIN_NS      = 1500;
  localparam int SMG_RST_MIN_CYC     =
    (SMG_RST_MIN_NS + SMG_CLK_PERIOD_NS - 1) / SMG_CLK_PERIOD_NS;
  localparam int SMG_RST_CNT_W       = 9;
  localparam int SMG_PORT_W          = 32;

endpackage

// ===== rtl/smg_sleep_mode_domain_gating.sv
// sleep mode domain gating: chooses which clock domains run per sleep mode,
// handles wake sources, external reset filtering and pin tri-state in reset
// assumes all inputs are synchronous to core_clk; the analog reset path that
// works without a clock lives outside, this block sees the sampled pin level
//
// Behaviour
// - six software-chosen sleep modes, each gating domains
// - idle stops cpu, peripherals and interrupts run
// - power-down halts oscillator until external interrupt or reset
// - power-save keeps asynchronous timer running
// - noise reduction keeps timer, converter, oscillator and interrupts
// - standby keeps main oscillator running
// - extended standby keeps oscillator and timer
// - long enough low reset pin causes reset
// - any reset tri-states all port pins
// - enabled test port keeps pull-ups during pin or otherResetReq reset; srst clears them
// - test data out driven only while shifting
`timescale 1ns/1ns
`default_nettype none

module smg_sleep_mode_domain_gating (
  input  wire logic                               core_clk,
  input  wire logic                               srst,
  input  wire logic                               clkEn,
  input  wire logic                               sleepEnable,
  input  wire logic                               sleepRequest,
  input  wire smg_pkg::smg_mode_t                 sleepMode,
  input  wire logic                               extResetPin_n,
  input  wire logic                               extIntWake,
  input  wire logic                               anyIntWake,
  input  wire logic                               asyncTimerIntWake,
  input  wire logic                               otherResetReq,
  input  wire logic                               testPortEnable,
  input  wire logic                               tapShiftState,
  input  wire logic [smg_pkg::SMG_PORT_W-1:0]     portDriveEnable,
  output logic      [smg_pkg::SMG_DOM_W-1:0]      domainRun,
  output logic                                    sleeping,
  output logic                                    resetActive,
  output logic      [smg_pkg::SMG_PORT_W-1:0]     portOutEnable,
  output logic                                    testPullupEnable,
  output logic                                    testDataOutEnable
);

  // ==========================================================
  // state record
  typedef struct packed {
    smg_pkg::smg_state_t                  state;
    smg_pkg::smg_mode_t                   mode;
    logic [smg_pkg::SMG_RST_CNT_W-1:0]    lowCount;
    logic [smg_pkg::SMG_DOM_W-1:0]        domains;
    logic [smg_pkg::SMG_PORT_W-1:0]       portOe;
    logic                                 testPull;
    logic                                 tdoOe;
  } smg_regs_t;

  smg_regs_t r;
  smg_regs_t next_r;

  // ==========================================================
  // domains that keep running in a given sleep mode
  function automatic logic [smg_pkg::SMG_DOM_W-1:0] smg_mode_domains(
    input smg_pkg::smg_mode_t m
  );
    logic [smg_pkg::SMG_DOM_W-1:0] d;
    d = smg_pkg::SMG_DOM_NONE;
    unique case (m)
      smg_pkg::SMG_MODE_IDLE: begin
        d = smg_pkg::SMG_DOM_ALL;
        d[smg_pkg::SMG_DOM_CPU] = 1'b0;
      end
      smg_pkg::SMG_MODE_ADCNR: begin
        d[smg_pkg::SMG_DOM_ADC]  = 1'b1;
        d[smg_pkg::SMG_DOM_ATMR] = 1'b1;
        d[smg_pkg::SMG_DOM_OSC]  = 1'b1;
        d[smg_pkg::SMG_DOM_INTR] = 1'b1;
      end
      smg_pkg::SMG_MODE_PDOWN: begin
        d = smg_pkg::SMG_DOM_NONE;
      end
      smg_pkg::SMG_MODE_PSAVE: begin
        d[smg_pkg::SMG_DOM_ATMR] = 1'b1;
      end
      smg_pkg::SMG_MODE_STBY: begin
        d[smg_pkg::SMG_DOM_OSC]  = 1'b1;
      end
      smg_pkg::SMG_MODE_XSTBY: begin
        d[smg_pkg::SMG_DOM_OSC]  = 1'b1;
        d[smg_pkg::SMG_DOM_ATMR] = 1'b1;
      end
      default: d = smg_pkg::SMG_DOM_ALL;
    endcase
    return d;
  endfunction

  // ==========================================================
  // wake decision for the mode held while asleep
  function automatic logic smg_wake(
    input smg_pkg::smg_mode_t m,
    input logic               extInt,
    input logic               anyInt,
    input logic               timerInt
  );
    logic w;
    w = extInt;
    unique case (m)
      smg_pkg::SMG_MODE_IDLE,
      smg_pkg::SMG_MODE_ADCNR: w = extInt | anyInt | timerInt;
      smg_pkg::SMG_MODE_PSAVE,
      smg_pkg::SMG_MODE_XSTBY: w = extInt | timerInt;
      smg_pkg::SMG_MODE_PDOWN,
      smg_pkg::SMG_MODE_STBY:  w = extInt;
      default:                 w = 1'b1;
    endcase
    return w;
  endfunction

  logic pinLowLong;
  logic inReset;

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    // count consecutive low cycles of the reset pin
    if (extResetPin_n) begin
      next_r.lowCount = '0;
    end else if (r.lowCount != smg_pkg::SMG_RST_CNT_W'(smg_pkg::SMG_RST_MIN_CYC)) begin
      next_r.lowCount = r.lowCount + 1'b1;
    end
    pinLowLong = !extResetPin_n &&
                 (r.lowCount == smg_pkg::SMG_RST_CNT_W'(smg_pkg::SMG_RST_MIN_CYC));
    inReset = pinLowLong || otherResetReq;

    unique case (r.state)
      smg_pkg::SMG_ST_RUN: begin
        if (inReset) begin
          next_r.state = smg_pkg::SMG_ST_RESET;
        end else if (sleepEnable && sleepRequest) begin
          next_r.state = smg_pkg::SMG_ST_SLEEP;
          next_r.mode  = sleepMode;
        end
      end
      smg_pkg::SMG_ST_SLEEP: begin
        if (inReset) begin
          next_r.state = smg_pkg::SMG_ST_RESET;
        end else if (smg_wake(r.mode, extIntWake, anyIntWake, asyncTimerIntWake)) begin
          next_r.state = smg_pkg::SMG_ST_RUN;
        end
      end
      smg_pkg::SMG_ST_RESET: begin
        if (!inReset && extResetPin_n) begin
          next_r.state = smg_pkg::SMG_ST_RUN;
        end
      end
      default: next_r.state = smg_pkg::SMG_ST_RESET;
    endcase

    // domain gating follows the next state
    unique case (next_r.state)
      smg_pkg::SMG_ST_SLEEP: next_r.domains = smg_mode_domains(next_r.mode);
      smg_pkg::SMG_ST_RESET: next_r.domains = smg_pkg::SMG_DOM_NONE;
      default:               next_r.domains = smg_pkg::SMG_DOM_ALL;
    endcase

    // pins: tri-state on any reset, pull-ups kept when test port enabled
    if (next_r.state == smg_pkg::SMG_ST_RESET) begin
      next_r.portOe = '0;
    end else begin
      next_r.portOe = portDriveEnable;
    end
    next_r.testPull = testPortEnable;
    next_r.tdoOe    = testPortEnable && tapShiftState;
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r.state    <= smg_pkg::SMG_ST_RESET;
      r.mode     <= smg_pkg::SMG_MODE_IDLE;
      r.lowCount <= '0;
      r.domains  <= smg_pkg::SMG_DOM_NONE;
      r.portOe   <= '0;
      r.testPull <= 1'b0;
      r.tdoOe    <= 1'b0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  assign domainRun         = r.domains;
  assign sleeping          = (r.state == smg_pkg::SMG_ST_SLEEP);
  assign resetActive       = (r.state == smg_pkg::SMG_ST_RESET);
  assign portOutEnable     = r.portOe;
  assign testPullupEnable  = r.testPull;
  assign testDataOutEnable = r.tdoOe;

endmodule

`default_nettype wire

// ===== verif/smg_board_model.sv
// board model: reset pin source and external interrupt source
// assumes core_clk from the bench; pin idles high by pull-up
`timescale 1ns/1ns
`default_nettype none
module smg_board_model (
  input  wire logic core_clk,
  output var  logic extResetPin_n,
  output var  logic extIntWake
);
  // ==========================================================
  // pin and interrupt drivers
  initial begin
    extResetPin_n = 1'h1;
    extIntWake = 1'h0;
  end
  task automatic pulse(input int n);
    extResetPin_n = 1'h0;
    repeat (n) @(posedge core_clk);
    #1 extResetPin_n = 1'h1;
  endtask
  task automatic wake();
    extIntWake = 1'h1;
    @(posedge core_clk);
    #1 extIntWake = 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== verif/smg_checker.sv
// port assertions for the sleep mode domain gating block
// assumes one core_clk domain, srst synchronous active high
`timescale 1ns/1ns
`default_nettype none
module smg_checker (
  input wire logic               core_clk,
  input wire logic               srst,
  input wire logic               clkEn,
  input wire logic               sleepEnable,
  input wire logic               sleepRequest,
  input wire smg_pkg::smg_mode_t sleepMode,
  input wire logic               extResetPin_n,
  input wire logic               extIntWake,
  input wire logic               asyncTimerIntWake,
  input wire logic               otherResetReq,
  input wire logic               testPortEnable,
  input wire logic               tapShiftState,
  input wire logic [5:0]         domainRun,
  input wire logic               sleeping,
  input wire logic               resetActive,
  input wire logic [31:0]        portOutEnable,
  input wire logic               testPullupEnable,
  input wire logic               testDataOutEnable
);
  // ==========================================================
  // low pin cycle counter
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  int lowCnt;
  logic calm;
  assign calm = clkEn && extResetPin_n && !otherResetReq;
  always_ff @(posedge core_clk) begin
    lowCnt <= (srst || extResetPin_n) ? 0 : lowCnt + 1;
  end
  function automatic logic [5:0] gate(input smg_pkg::smg_mode_t m);
    case (m)
      smg_pkg::SMG_MODE_IDLE:  return 6'h3E;
      smg_pkg::SMG_MODE_ADCNR: return 6'h3C;
      smg_pkg::SMG_MODE_PSAVE: return 6'h10;
      smg_pkg::SMG_MODE_STBY:  return 6'h08;
      smg_pkg::SMG_MODE_XSTBY: return 6'h18;
      default:                 return 6'h00;
    endcase
  endfunction
  a_reset_tristate: assert property (resetActive |-> portOutEnable == '0)
    else $error("port enables driven in reset");
  a_pullup_copy: assert property ($past(clkEn && !srst) |->
    testPullupEnable == $past(testPortEnable)) else $error("pull-up enable wrong");
  a_tdo_shift: assert property ($past(clkEn && !srst) |->
    testDataOutEnable == $past(testPortEnable && tapShiftState)) else $error("tdo enable wrong");
  a_sleep_entry: assert property (calm && !sleeping && !resetActive && sleepEnable
    && sleepRequest |=> sleeping) else $error("sleep not entered");
  a_mode_gates: assert property ($rose(sleeping) |-> domainRun == gate($past(sleepMode)))
    else $error("domain gating wrong for mode");
  a_ext_wake: assert property (calm && sleeping && extIntWake |=>
    !sleeping && domainRun == 6'h3F) else $error("external wake failed");
  a_timer_wake: assert property (calm && sleeping && domainRun[4] && asyncTimerIntWake
    |=> domainRun == 6'h3F) else $error("timer wake failed");
  a_pin_reset: assert property (lowCnt > smg_pkg::SMG_RST_MIN_CYC + 1 |->
    resetActive && domainRun == '0) else $error("long pin pulse gave no reset");
endmodule
`default_nettype wire

// ===== verif/smg_sleep_mode_domain_gating_tb.sv
// bench for sleep mode domain gating, random port traffic per mode
// assumes checker and board model compiled before it
`timescale 1ns/1ns
`default_nettype none
module smg_sleep_mode_domain_gating_tb;
  // ==========================================================
  // stimulus and checking
  logic core_clk = 0, srst = 1, clkEn = 1, sleepEnable = 0, sleepRequest = 0;
  logic anyIntWake = 0, asyncTimerIntWake = 0, otherResetReq = 0, testPortEnable = 0;
  logic tapShiftState = 0, extResetPin_n, extIntWake, sleeping, resetActive;
  logic testPullupEnable, testDataOutEnable;
  logic [31:0] portDriveEnable = '0, portOutEnable;
  logic [5:0] domainRun;
  smg_pkg::smg_mode_t sleepMode = smg_pkg::SMG_MODE_IDLE;
  int err_count = 0, num_checks = 0, cycles = 0;
  smg_sleep_mode_domain_gating uut (.core_clk, .srst, .clkEn, .sleepEnable, .sleepRequest,
    .sleepMode, .extResetPin_n, .extIntWake, .anyIntWake, .asyncTimerIntWake, .otherResetReq,
    .testPortEnable, .tapShiftState, .portDriveEnable, .domainRun, .sleeping, .resetActive,
    .portOutEnable, .testPullupEnable, .testDataOutEnable);
  smg_board_model partner (.core_clk, .extResetPin_n, .extIntWake);
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cycles > 5000) begin err_count++; give_verdict(); end
  task automatic check(input string what, input logic [32:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [5:0] gate(input smg_pkg::smg_mode_t m);
    return m == smg_pkg::SMG_MODE_IDLE ? 6'h3E : m == smg_pkg::SMG_MODE_ADCNR ? 6'h3C :
      m == smg_pkg::SMG_MODE_PSAVE ? 6'h10 : m == smg_pkg::SMG_MODE_STBY ? 6'h08 :
      m == smg_pkg::SMG_MODE_XSTBY ? 6'h18 : 6'h00;
  endfunction
  initial begin
    smg_pkg::smg_mode_t m;
    void'($urandom(16072));
    tick(4);
    check("resetPorts", portOutEnable, '0);
    srst = 0;
    tick(2);
    sleepRequest = 1;
    tick();
    sleepRequest = 0;
    check("refusedSleep", {sleeping, domainRun}, 7'h3F);
    {clkEn, sleepEnable, sleepRequest} = 3'h3;
    tick();
    {clkEn, sleepEnable, sleepRequest} = 3'h4;
    check("frozenSleep", {sleeping, domainRun}, 7'h3F);
    m = m.first();
    repeat (6) begin
      portDriveEnable = $urandom();
      {testPortEnable, tapShiftState} = 2'($urandom());
      {sleepMode, sleepEnable, sleepRequest} = {m, 2'h3};
      tick();
      {sleepEnable, sleepRequest} = 2'h0;
      check("modeGates", domainRun, gate(m));
      check("portFollow", portOutEnable, portDriveEnable);
      check("pullup", testPullupEnable, testPortEnable);
      check("tdoEnable", testDataOutEnable, testPortEnable & tapShiftState);
      anyIntWake = 1;
      tick();
      anyIntWake = 0;
      check("anyWake", sleeping, m > smg_pkg::SMG_MODE_ADCNR);
      if (m inside {smg_pkg::SMG_MODE_PSAVE, smg_pkg::SMG_MODE_XSTBY}) begin
        asyncTimerIntWake = 1;
        tick();
        asyncTimerIntWake = 0;
      end else if (sleeping) partner.wake();
      check("wakeAll", domainRun, 6'h3F);
      m = m.next();
    end
    otherResetReq = 1;
    tick();
    otherResetReq = 0;
    check("otherReset", {resetActive, portOutEnable}, 33'h1_0000_0000);
    tick(2);
    partner.pulse(380);
    check("pinReset", {resetActive, domainRun}, 7'h40);
    tick(2);
    check("pinRelease", domainRun, 6'h3F);
    give_verdict();
  end
endmodule
bind smg_sleep_mode_domain_gating smg_checker chk (.core_clk, .srst, .clkEn, .sleepEnable,
  .sleepRequest, .sleepMode, .extResetPin_n, .extIntWake, .asyncTimerIntWake, .otherResetReq,
  .testPortEnable, .tapShiftState, .domainRun, .sleeping, .resetActive, .portOutEnable,
  .testPullupEnable, .testDataOutEnable);
`default_nettype wire
